//--- core/nfc_rf_regs.svh
`ifndef NFC_RF_REGS_SVH
`define NFC_RF_REGS_SVH

// Register byte offsets on the APB bus.
`define CTRL_OFF        8'h00
`define RXCFG_OFF       8'h04
`define GAIN_OFF        8'h08
`define STATUS_OFF      8'h0c
`define RXDATA_OFF      8'h10
`define TXDATA_OFF      8'h14

// Control register fields.
`define CTRL_SPEED_LO   0
`define CTRL_INIT_REQ   2
`define CTRL_TXN        3
`define CTRL_INV_A      4
`define CTRL_INV_B      5
`define CTRL_DEPTH_LO   6
`define CTRL_ENV_PAUSE  9
`define CTRL_ACT_LM     10
`define CTRL_CARD_ADC   11
`define CTRL_GAIN_EN    12
`define CTRL_DET_EN     13
`define CTRL_SENS_LO    14
`define CTRL_WIDTH      18

// Receiver configuration fields.
`define RXCFG_HP_LO     0
`define RXCFG_GAIN_LO   2
`define RXCFG_I_EN      7
`define RXCFG_Q_EN      8

// Status register fields.
`define ST_MODE_FLAG    0
`define ST_CARD_FLAG    1
`define ST_RX_VALID     2
`define ST_MODE_F       3
`define ST_RF_ON        4
`define ST_FIELD        5
`define ST_TX_BUSY      6
`define ST_RX_BUSY      7
`define ST_STATE_LO     8

// Reset values and the baseband gain ceiling.
`define CTRL_RESET      18'h00000
`define RXCFG_RESET     9'h180
`define GAIN_RESET      10'h000
`define BB_GAIN_MAX     5'h1e

// Timing: carrier periods per bit, half bit, mid-bit window and subcarrier.
`define BIT_CARRIERS    7'h7f
`define HALF_BIT        6
`define MID_LO          7'h20
`define MID_HI          7'h5f
`define SUBCARRIER_BIT  3
`define INIT_DELAY_CARRIERS 4096
`define CLOCK_NS        5
`define GAIN_SAMPLE_NS  1000
`define GAIN_SAMPLE_CYCLES ((`GAIN_SAMPLE_NS + `CLOCK_NS - 1) / `CLOCK_NS)

`endif

//--- core/nfc_rf_pkg.sv
package nfc_rf_pkg;

	// Peer-to-peer start-up states, Gray coded along the usual path.
	typedef enum logic [1:0] {
		P2P_TARGET = 2'b00,
		P2P_WAIT   = 2'b01,
		P2P_INIT   = 2'b11
	} p2p_state_t;

	// Transfer speed selection.
	typedef enum logic [1:0] {
		SPEED_106 = 2'b00,
		SPEED_212 = 2'b01,
		SPEED_424 = 2'b10
	} speed_t;

endpackage

//--- core/nfc_rf_interface_control.sv
`timescale 1ns/1ps
`include "nfc_rf_regs.svh"

module nfc_rf_interface_control
	import nfc_rf_pkg::*;
#(
	parameter int INIT_DELAY_CARRIERS = `INIT_DELAY_CARRIERS,
	parameter int GAIN_SAMPLE_CYCLES  = `GAIN_SAMPLE_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        carrier_in,
	input  wire logic        pause_in,
	input  wire logic        shallow_mod_in,
	input  wire logic        field_det_in,
	input  wire logic        peak_cmp_pos,
	input  wire logic        detune_in,
	output logic             antenna_drive_a,
	output logic             antenna_drive_b,
	output logic             rf_on,
	output logic             env_out,
	output logic      [2:0]  mod_depth,
	output logic             load_mod_out,
	output logic             framing_f,
	output logic      [1:0]  hp_corner,
	output logic      [4:0]  bb_gain,
	output logic             i_chan_en,
	output logic             q_chan_en,
	output logic             field_det_en,
	output logic      [9:0]  gain_resistor_setting,
	output logic             init_start
);

	// Saturating single step of the resistor code; up means lower resistance.
	function automatic logic [9:0] sat_step(input logic [9:0] code, input logic up);
		if (up) begin
			sat_step = (code == 10'h3ff) ? code : code + 10'h001;
		end else begin
			sat_step = (code == 10'h000) ? code : code - 10'h001;
		end
	endfunction

	logic [5:0]              s1_ff;           // First synchroniser stage.
	logic [5:0]              s2_ff;           // Second synchroniser stage.
	logic [5:0]              s3_ff;           // Third synchroniser stage.
	logic [5:0]              lvl_ff;          // Agreed input levels.
	logic [5:0]              lvl_d_ff;        // Agreed levels one cycle back.
	logic [`CTRL_WIDTH-1:0]  ctrl_ff;         // Control register.
	logic [8:0]              rxcfg_ff;        // Receiver configuration.
	logic                    mode_flag_ff;    // Field classified, sticky.
	logic                    card_flag_ff;    // Card detected, sticky.
	logic                    rx_valid_ff;     // Received word ready, sticky.
	logic                    mode_f_ff;       // Last class was type F.
	logic                    det_done_ff;     // Class already made for this field.
	logic [8:0]              rx_data_ff;      // Last received byte with parity.
	p2p_state_t              state_ff;        // Peer-to-peer start-up state.
	logic [31:0]             delay_ff;        // Quiet carrier periods seen.
	logic                    rx_busy_ff;      // Frame reception running.
	logic [6:0]              rx_cnt_ff;       // Carrier position in the bit.
	logic                    mid_ff;          // Pause seen mid-bit.
	logic                    start_ff;        // Pause seen at bit start.
	logic                    early_ff;        // Pause belongs to next bit start.
	logic                    last_zero_ff;    // Previous bit was a zero.
	logic [8:0]              rx_shift_ff;     // Receive shift register.
	logic [3:0]              rx_nbits_ff;     // Bits in the shift register.
	logic                    tx_busy_ff;      // Answer in progress.
	logic [9:0]              tx_word_ff;      // Start bit, data, parity.
	logic [3:0]              tx_nbits_ff;     // Bits still to send after this one.
	logic [6:0]              tx_cnt_ff;       // Carrier position in the bit.
	logic [31:0]             tick_cnt_ff;     // Gain sample divider.
	logic [3:0]              run_ff;          // Consecutive detuned samples.

	logic        carrier_tick;  // Rising carrier edge.
	logic        pause_start;   // Start of a full pause.
	logic        shallow_start; // Start of a shallow modulation.
	logic        gain_tick;     // Gain and detection sample enable.
	logic        wr_en;         // APB write taken this edge.
	logic        codec_on;      // Type A codec active.
	logic        txn_busy;      // Transaction in progress.
	logic        mod_active;    // Subcarrier answer modulating now.
	logic        rx_bit_end;    // Last carrier period of a received bit.
	logic        rx_bit;        // Decoded bit value.
	logic        rx_take;       // Decoded bit is data.

	assign carrier_tick  = lvl_ff[0] & ~lvl_d_ff[0];
	assign pause_start   = lvl_ff[1] & ~lvl_d_ff[1];
	assign shallow_start = lvl_ff[2] & ~lvl_d_ff[2];
	assign gain_tick     = (tick_cnt_ff == 32'(GAIN_SAMPLE_CYCLES - 1));
	assign wr_en         = psel & penable & pready & pwrite;
	assign codec_on      = (ctrl_ff[`CTRL_SPEED_LO +: 2] == SPEED_106) &&
			(state_ff != P2P_INIT);
	assign txn_busy      = ctrl_ff[`CTRL_TXN] | rx_busy_ff | tx_busy_ff;
	assign rx_bit_end    = rx_busy_ff & carrier_tick & (rx_cnt_ff == `BIT_CARRIERS);
	assign rx_bit        = mid_ff;
	assign rx_take       = mid_ff | start_ff | ~last_zero_ff;
	// Manchester: a one modulates the first half, a zero the second half.
	assign mod_active    = tx_busy_ff & tx_cnt_ff[`SUBCARRIER_BIT] &
			(tx_word_ff[0] ^ tx_cnt_ff[`HALF_BIT]);

	// Three-stage synchronisers; a level counts once stages two and three agree.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_ff    <= 6'h00;
			s2_ff    <= 6'h00;
			s3_ff    <= 6'h00;
			lvl_ff   <= 6'h00;
			lvl_d_ff <= 6'h00;
		end else begin
			s1_ff    <= {detune_in, peak_cmp_pos, field_det_in, shallow_mod_in,
					pause_in, carrier_in};
			s2_ff    <= s1_ff;
			s3_ff    <= s2_ff;
			lvl_ff   <= (s2_ff & s3_ff) | (lvl_ff & (s2_ff ^ s3_ff));
			lvl_d_ff <= lvl_ff;
		end
	end

	// APB slave: zero wait states, error on unmapped addresses.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (psel && !penable) begin
				case (paddr)
					`CTRL_OFF:   prdata <= 32'(ctrl_ff);
					`RXCFG_OFF:  prdata <= 32'(rxcfg_ff);
					`GAIN_OFF:   prdata <= 32'(gain_resistor_setting);
					`STATUS_OFF: prdata <= 32'({state_ff, rx_busy_ff, tx_busy_ff,
							lvl_ff[3], rf_on, mode_f_ff, rx_valid_ff,
							card_flag_ff, mode_flag_ff});
					`RXDATA_OFF: prdata <= 32'(rx_data_ff);
					`TXDATA_OFF: prdata <= 32'(tx_word_ff[8:1]);
					default:     pslverr <= 1'b1;
				endcase
			end
		end
	end

	// Control and receiver configuration registers.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctrl_ff  <= `CTRL_RESET;
			rxcfg_ff <= `RXCFG_RESET;
		end else if (wr_en && paddr == `CTRL_OFF) begin
			ctrl_ff <= pwdata[`CTRL_WIDTH-1:0];
			if (txn_busy) begin
				// The speed stays put while a transaction runs.
				ctrl_ff[`CTRL_SPEED_LO +: 2] <= ctrl_ff[`CTRL_SPEED_LO +: 2];
			end else if (pwdata[`CTRL_SPEED_LO +: 2] == 2'b11) begin
				ctrl_ff[`CTRL_SPEED_LO +: 2] <= SPEED_424;
			end
		end else if (wr_en && paddr == `RXCFG_OFF) begin
			rxcfg_ff <= pwdata[8:0];
			if (pwdata[`RXCFG_GAIN_LO +: 5] > `BB_GAIN_MAX) begin
				rxcfg_ff[`RXCFG_GAIN_LO +: 5] <= `BB_GAIN_MAX;
			end
		end
	end

	// Receiver front-end settings driven out from registers.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			hp_corner <= 2'h0;
			bb_gain   <= 5'h00;
			i_chan_en <= 1'b0;
			q_chan_en <= 1'b0;
			framing_f <= 1'b0;
		end else begin
			hp_corner <= rxcfg_ff[`RXCFG_HP_LO +: 2];
			bb_gain   <= rxcfg_ff[`RXCFG_GAIN_LO +: 5];
			i_chan_en <= rxcfg_ff[`RXCFG_I_EN];
			q_chan_en <= rxcfg_ff[`RXCFG_Q_EN] & ~ctrl_ff[`CTRL_CARD_ADC];
			framing_f <= (ctrl_ff[`CTRL_SPEED_LO +: 2] != SPEED_106);
		end
	end

	// Peer-to-peer start-up: target by default, initiator only on request.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_ff   <= P2P_TARGET;
			delay_ff   <= 32'h0000_0000;
			init_start <= 1'b0;
		end else begin
			init_start <= 1'b0;
			case (state_ff)
				P2P_TARGET: begin
					delay_ff <= 32'h0000_0000;
					if (ctrl_ff[`CTRL_INIT_REQ]) begin
						state_ff <= P2P_WAIT;
					end
				end
				P2P_WAIT: begin
					if (!ctrl_ff[`CTRL_INIT_REQ]) begin
						state_ff <= P2P_TARGET;
					end else if (lvl_ff[3]) begin
						delay_ff <= 32'h0000_0000;
					end else if (carrier_tick) begin
						if (delay_ff == 32'(INIT_DELAY_CARRIERS - 1)) begin
							state_ff   <= P2P_INIT;
							init_start <= 1'b1;
						end else begin
							delay_ff <= delay_ff + 32'h0000_0001;
						end
					end
				end
				P2P_INIT: begin
					if (!ctrl_ff[`CTRL_INIT_REQ]) begin
						state_ff <= P2P_TARGET;
					end
				end
				default: state_ff <= P2P_TARGET;
			endcase
		end
	end

	// Transmitter: carrier gated by the envelope, optional inversion per output.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rf_on           <= 1'b0;
			env_out         <= 1'b0;
			mod_depth       <= 3'h0;
			field_det_en    <= 1'b1;
			antenna_drive_a <= 1'b0;
			antenna_drive_b <= 1'b0;
			load_mod_out    <= 1'b0;
		end else begin
			rf_on        <= (state_ff == P2P_INIT);
			field_det_en <= (state_ff != P2P_INIT);
			env_out      <= (state_ff == P2P_INIT) & ~ctrl_ff[`CTRL_ENV_PAUSE];
			mod_depth    <= ctrl_ff[`CTRL_DEPTH_LO +: 3];
			load_mod_out <= mod_active & ~ctrl_ff[`CTRL_ACT_LM];
			if (state_ff == P2P_INIT &&
					(!ctrl_ff[`CTRL_ENV_PAUSE] || ctrl_ff[`CTRL_DEPTH_LO +: 3] != 3'h0)) begin
				// Depth zero means a full pause blanks the carrier.
				antenna_drive_a <= lvl_ff[0] ^ ctrl_ff[`CTRL_INV_A];
				antenna_drive_b <= lvl_ff[0] ^ ctrl_ff[`CTRL_INV_B];
			end else if (mod_active && ctrl_ff[`CTRL_ACT_LM]) begin
				// Weak field in antiphase with the reader carrier.
				antenna_drive_a <= ~lvl_ff[0];
				antenna_drive_b <= ~lvl_ff[0] ^ (ctrl_ff[`CTRL_INV_A] ^ ctrl_ff[`CTRL_INV_B]);
			end else begin
				antenna_drive_a <= 1'b0;
				antenna_drive_b <= 1'b0;
			end
		end
	end

	// Modified Miller decoder; a zero after a zero with no pause ends the frame.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rx_busy_ff   <= 1'b0;
			rx_cnt_ff    <= 7'h00;
			mid_ff       <= 1'b0;
			start_ff     <= 1'b0;
			early_ff     <= 1'b0;
			last_zero_ff <= 1'b0;
			rx_shift_ff  <= 9'h000;
			rx_nbits_ff  <= 4'h0;
			rx_data_ff   <= 9'h000;
		end else if (!codec_on) begin
			rx_busy_ff <= 1'b0;
		end else if (!rx_busy_ff) begin
			if (pause_start) begin
				// The start pause opens a zero slot counted one ahead of the byte.
				rx_busy_ff   <= 1'b1;
				rx_cnt_ff    <= 7'h00;
				mid_ff       <= 1'b0;
				start_ff     <= 1'b1;
				early_ff     <= 1'b0;
				last_zero_ff <= 1'b1;
				rx_nbits_ff  <= 4'hf;
			end
		end else begin
			if (carrier_tick) begin
				rx_cnt_ff <= rx_cnt_ff + 7'h01;
			end
			if (pause_start) begin
				if (rx_cnt_ff >= `MID_LO && rx_cnt_ff <= `MID_HI) begin
					mid_ff <= 1'b1;
				end else if (rx_cnt_ff > `MID_HI) begin
					early_ff <= 1'b1;
				end else begin
					start_ff <= 1'b1;
				end
			end
			if (rx_bit_end) begin
				mid_ff   <= 1'b0;
				start_ff <= early_ff;
				early_ff <= 1'b0;
				if (!rx_take) begin
					rx_busy_ff <= 1'b0;
				end else begin
					last_zero_ff <= ~rx_bit;
					rx_shift_ff  <= {rx_bit, rx_shift_ff[8:1]};
					rx_nbits_ff  <= (rx_nbits_ff == 4'h8) ? 4'h0 : rx_nbits_ff + 4'h1;
					if (rx_nbits_ff == 4'h8) begin
						rx_data_ff <= {rx_bit, rx_shift_ff[8:1]};
					end
				end
			end
		end
	end

	// Card answer: start bit, eight data bits LSB first, odd parity.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tx_busy_ff  <= 1'b0;
			tx_word_ff  <= 10'h000;
			tx_nbits_ff <= 4'h0;
			tx_cnt_ff   <= 7'h00;
		end else if (!tx_busy_ff) begin
			if (wr_en && paddr == `TXDATA_OFF && codec_on) begin
				tx_busy_ff  <= 1'b1;
				tx_word_ff  <= {~^pwdata[7:0], pwdata[7:0], 1'b1};
				tx_nbits_ff <= 4'h9;
				tx_cnt_ff   <= 7'h00;
			end
		end else if (carrier_tick) begin
			tx_cnt_ff <= tx_cnt_ff + 7'h01;
			if (tx_cnt_ff == `BIT_CARRIERS) begin
				tx_word_ff  <= {1'b0, tx_word_ff[9:1]};
				tx_nbits_ff <= tx_nbits_ff - 4'h1;
				if (tx_nbits_ff == 4'h0) begin
					tx_busy_ff <= 1'b0;
				end
			end
		end
	end

	// Gain loop sample divider.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tick_cnt_ff <= 32'h0000_0000;
		end else begin
			tick_cnt_ff <= gain_tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
		end
	end

	// Resistor code: zero is the highest resistance, all ones the lowest.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			gain_resistor_setting <= `GAIN_RESET;
		end else if (wr_en && paddr == `GAIN_OFF) begin
			gain_resistor_setting <= pwdata[9:0];
		end else if (ctrl_ff[`CTRL_GAIN_EN] && gain_tick) begin
			// Peak above reference asks for a lower resistance.
			gain_resistor_setting <= sat_step(gain_resistor_setting, lvl_ff[4]);
		end
	end

	// Mode detector and card detection with sticky, write-one-to-clear flags.
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mode_flag_ff <= 1'b0;
			card_flag_ff <= 1'b0;
			rx_valid_ff  <= 1'b0;
			mode_f_ff    <= 1'b0;
			det_done_ff  <= 1'b0;
			run_ff       <= 4'h0;
		end else begin
			// A set in the same cycle as a clear wins.
			if (wr_en && paddr == `STATUS_OFF) begin
				mode_flag_ff <= mode_flag_ff & ~pwdata[`ST_MODE_FLAG];
				card_flag_ff <= card_flag_ff & ~pwdata[`ST_CARD_FLAG];
				rx_valid_ff  <= rx_valid_ff & ~pwdata[`ST_RX_VALID];
			end
			if (rx_bit_end && rx_take && rx_nbits_ff == 4'h8) begin
				rx_valid_ff <= 1'b1;
			end
			if (!lvl_ff[3]) begin
				det_done_ff <= 1'b0;
			end else if (!det_done_ff && state_ff != P2P_INIT &&
					(pause_start || shallow_start)) begin
				det_done_ff  <= 1'b1;
				mode_f_ff    <= ~pause_start;
				mode_flag_ff <= 1'b1;
			end
			if (!ctrl_ff[`CTRL_DET_EN]) begin
				run_ff <= 4'h0;
			end else if (gain_tick) begin
				if (!lvl_ff[5]) begin
					run_ff <= 4'h0;
				end else if (run_ff == ctrl_ff[`CTRL_SENS_LO +: 4]) begin
					card_flag_ff <= 1'b1;
				end else begin
					run_ff <= run_ff + 4'h1;
				end
			end
		end
	end

endmodule

//--- tb/nfc_rf_interface_control_asserts.sv
`timescale 1ns/1ps
// Watches start-up, envelope, gain and framing behaviour from the ports alone.
module nfc_rf_checker
	import nfc_rf_pkg::*;
#(
	parameter int INIT_DELAY_CARRIERS = 8,
	parameter int GAIN_SAMPLE_CYCLES  = 4
) (
	input wire logic		clock,
	input wire logic		reset_n,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [7:0]	paddr,
	input wire logic		pready,
	input wire logic		carrier_in,
	input wire logic		field_det_in,
	input wire logic		rf_on,
	input wire logic		init_start,
	input wire logic		field_det_en,
	input wire logic		env_out,
	input wire logic		framing_f,
	input wire logic		load_mod_out,
	input wire logic [9:0]	gain_resistor_setting
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic			ctrl_wr;	// A control write completes now.
	logic			gain_wr;	// A gain code write completes now.
	logic [1:0]		car_ff;		// Carrier samples, used to find its rising edges.
	logic [15:0]	quiet_ff;	// Carrier rises since an outside field was last seen.
	assign ctrl_wr = psel & penable & pready & pwrite & (paddr == 8'h00);
	assign gain_wr = psel & penable & pready & pwrite & (paddr == 8'h08);
	// Counts quiet carrier periods; any outside field restarts the count.
	always_ff @(posedge clock) begin
		car_ff <= {car_ff[0], carrier_in};
		if (!reset_n || field_det_in)
			quiet_ff <= 16'h0000;
		else if (car_ff == 2'b01 && quiet_ff != 16'hffff)
			quiet_ff <= quiet_ff + 16'h0001;
	end
	sequence s_field_up;
		init_start ##1 rf_on;
	endsequence
	property p_start_field;
		init_start |-> s_field_up;
	endproperty
	a_start_field: assert property (p_start_field) else $error("field off after start");
	property p_quiet;
		init_start |-> quiet_ff >= INIT_DELAY_CARRIERS - 1;
	endproperty
	a_quiet: assert property (p_quiet) else $error("field on too soon");
	property p_cause;
		$rose(rf_on) |-> $past(init_start);
	endproperty
	a_cause: assert property (p_cause) else $error("field on without start");
	property p_detect;
		!rf_on && $past(reset_n) |-> field_det_en;
	endproperty
	a_detect: assert property (p_detect) else $error("detector off as target");
	property p_env;
		env_out |-> rf_on || $past(rf_on);
	endproperty
	a_env: assert property (p_env) else $error("envelope without field");
	property p_gain_step;
		$changed(gain_resistor_setting) && !$past(gain_wr) && !$past(gain_wr, 2) |->
			({1'b0, gain_resistor_setting} - $past(gain_resistor_setting)) inside {11'h001, 11'h7ff};
	endproperty
	a_gain_step: assert property (p_gain_step) else $error("gain step wrong");
	property p_speed;
		!$past(ctrl_wr) && !$past(ctrl_wr, 2) |-> $stable(framing_f);
	endproperty
	a_speed: assert property (p_speed) else $error("framing changed alone");
	property p_answer;
		load_mod_out |-> !rf_on;
	endproperty
	a_answer: assert property (p_answer) else $error("answer as initiator");
endmodule

bind nfc_rf_interface_control nfc_rf_checker #(.INIT_DELAY_CARRIERS(INIT_DELAY_CARRIERS),
	.GAIN_SAMPLE_CYCLES(GAIN_SAMPLE_CYCLES)) chk (.clock(clock), .reset_n(reset_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
	.carrier_in(carrier_in), .field_det_in(field_det_in), .rf_on(rf_on),
	.init_start(init_start), .field_det_en(field_det_en), .env_out(env_out),
	.framing_f(framing_f), .load_mod_out(load_mod_out),
	.gain_resistor_setting(gain_resistor_setting));

//--- tb/rf_peer_model.sv
`timescale 1ns/1ps
// Far side across the field: free carrier, field, pauses and comparator levels.
module rf_peer_model (
	input wire logic	field_req,
	input wire logic	pause_req,
	input wire logic	shallow_req,
	input wire logic	peak_req,
	input wire logic	detune_req,
	input wire logic	load_mod_out,
	output logic		carrier_in,
	output logic		pause_in,
	output logic		shallow_mod_in,
	output logic		field_det_in,
	output logic		peak_cmp_pos,
	output logic		detune_in,
	output logic [15:0]	answer_edges
);
	// The carrier runs free with a 160 ns period and an odd phase offset.
	initial begin
		carrier_in = 1'b0;
		#37;
		forever #80 carrier_in = ~carrier_in;
	end
	// Lines start quiet, then move on falling carrier edges; modulation needs a field.
	initial begin
		{pause_in, shallow_mod_in, field_det_in, peak_cmp_pos, detune_in} = 5'h00;
		forever @(negedge carrier_in) begin
			field_det_in <= field_req;
			pause_in <= field_req & pause_req;
			shallow_mod_in <= field_req & shallow_req & !pause_req;
			peak_cmp_pos <= peak_req;
			detune_in <= detune_req;
		end
	end
	// Counts answer subcarrier pulses as a reader would see them.
	initial begin
		answer_edges = 16'h0000;
		forever @(posedge load_mod_out)
			answer_edges <= answer_edges + 16'h0001;
	end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
// Drives registers over APB and the field through the peer, and checks outputs.
module testbench
	import nfc_rf_pkg::*;
;
	logic			clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic			fld = 1'b0, pau = 1'b0, shl = 1'b0, pk = 1'b0, dtn = 1'b0, err;
	logic [7:0]		paddr = 8'h00;
	logic [31:0]	pwdata = 32'h0, rdata;
	logic [31:0]	prdata;
	logic			pready, pslverr, carrier_in, pause_in, shallow_mod_in, field_det_in;
	logic			peak_cmp_pos, detune_in, antenna_drive_a, antenna_drive_b, rf_on, env_out;
	logic			load_mod_out, framing_f, i_chan_en, q_chan_en, field_det_en, init_start;
	logic [2:0]		mod_depth;
	logic [1:0]		hp_corner;
	logic [4:0]		bb_gain;
	logic [9:0]		gain_resistor_setting;
	logic [15:0]	answer_edges;
	int				err_total = 0, num_checks = 0, cycles = 0, i, n;
	nfc_rf_interface_control #(.INIT_DELAY_CARRIERS(8), .GAIN_SAMPLE_CYCLES(4)) DUT (
		.clock, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .carrier_in, .pause_in, .shallow_mod_in, .field_det_in, .peak_cmp_pos,
		.detune_in, .antenna_drive_a, .antenna_drive_b, .rf_on, .env_out, .mod_depth,
		.load_mod_out, .framing_f, .hp_corner, .bb_gain, .i_chan_en, .q_chan_en,
		.field_det_en, .gain_resistor_setting, .init_start);
	rf_peer_model peer (.field_req(fld), .pause_req(pau), .shallow_req(shl), .peak_req(pk),
		.detune_req(dtn), .load_mod_out, .carrier_in, .pause_in, .shallow_mod_in,
		.field_det_in, .peak_cmp_pos, .detune_in, .answer_edges);
	// The 200 MHz clock.
	always #2.5 clock = ~clock;
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Cuts a hang short once the cycle ceiling is reached.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 80000) begin
			err_total++;
			wrap_up();
		end
	end
	// Compares one seen value with the expected one.
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One APB transfer, held in the access phase until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	// Reads a register and compares the masked word.
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		check(nm, rdata & m, e);
	endtask
	// Lets some edges pass, then samples between edges.
	task automatic settle(input int c);
		repeat (c) @(posedge clock);
		@(negedge clock);
	endtask
	// Sends a reader frame: start pause, nine bits LSB first, a zero, then silence.
	task automatic frame(input logic [8:0] b);
		logic [11:0] s;	// Bit of each slot; slot 0 is the start of frame.
		logic        z;	// The previous slot was a zero.
		int          o;	// Pause offset in carrier periods, 128 for no pause.
		s = {2'b00, b, 1'b0};
		z = 1'b1;
		for (int k = 0; k < 12; k++) begin
			o = (k == 11) ? 128 : s[k] ? 64 : z ? 0 : 128;
			repeat (o) @(posedge carrier_in);
			if (o < 128) begin
				@(posedge clock) pau <= 1'b1;
				repeat (4) @(posedge carrier_in);
				@(posedge clock) pau <= 1'b0;
				repeat (124 - o) @(posedge carrier_in);
			end
			z = ~s[k];
		end
	endtask
	// Main sequence of tests.
	initial begin
		repeat (2) @(posedge clock);
		reset_n <= 1'b1;
		rd(8'h00, 32'hffffffff, 32'h0, "ctrl");
		rd(8'h04, 32'hffffffff, 32'h180, "rxcfg");
		rd(8'h08, 32'hffffffff, 32'h0, "gain");
		check("rf_on", rf_on, 1'b0);
		check("detector", field_det_en, 1'b1);
		apb(1'b0, 8'h20, 32'h0);
		check("slverr", err, 1'b1);
		$display("reset test done");
		for (i = 0; i < 4; i++) begin
			wr(8'h04, 32'h1fc | i);
			settle(1);
			check("corner", hp_corner, i);
		end
		check("bb gain", bb_gain, 5'h1e);
		wr(8'h04, 32'h080);
		settle(1);
		check("q off", q_chan_en, 1'b0);
		wr(8'h04, 32'h180);
		wr(8'h00, 32'h800);
		settle(1);
		check("card adc", {i_chan_en, q_chan_en}, 2'b10);
		$display("receiver test done");
		for (i = 0; i < 3; i++) begin
			wr(8'h00, i);
			settle(2);
			check("framing", framing_f, i != 0);
		end
		wr(8'h00, 32'h9);
		wr(8'h00, 32'ha);
		rd(8'h00, 32'h3, 32'h1, "speed held");
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h0);
		rd(8'h00, 32'h3, 32'h0, "speed free");
		$display("speed test done");
		@(posedge clock) fld <= 1'b1;
		wr(8'h00, 32'h154);
		settle(600);
		check("wait rf", rf_on, 1'b0);
		rd(8'h0c, 32'h300, 32'h100, "state");
		@(posedge clock) fld <= 1'b0;
		n = 0;
		while (init_start !== 1'b1 && n < 2000) begin
			@(posedge clock);
			n++;
		end
		check("quiet time", n >= 224 && n < 2000, 1'b1);
		settle(2);
		check("initiator", {rf_on, field_det_en, env_out, mod_depth}, 6'h2d);
		check("antiphase", antenna_drive_a ^ antenna_drive_b, 1'b1);
		wr(8'h00, 32'h354);
		settle(2);
		check("env pause", env_out, 1'b0);
		wr(8'h00, 32'h0);
		settle(2);
		check("target", {rf_on, field_det_en}, 2'b01);
		$display("start-up test done");
		wr(8'h08, 32'h3fd);
		@(posedge clock) pk <= 1'b1;
		wr(8'h00, 32'h1000);
		settle(200);
		rd(8'h08, 32'h3ff, 32'h3ff, "gain top");
		@(posedge clock) pk <= 1'b0;
		wr(8'h08, 32'h2);
		settle(200);
		rd(8'h08, 32'h3ff, 32'h0, "gain floor");
		wr(8'h00, 32'ha000);
		@(posedge clock) dtn <= 1'b1;
		settle(3000);
		rd(8'h0c, 32'h2, 32'h2, "card");
		@(posedge clock) dtn <= 1'b0;
		settle(100);
		wr(8'h0c, 32'h2);
		rd(8'h0c, 32'h2, 32'h0, "card clear");
		wr(8'h00, 32'h0);
		$display("gain and detect test done");
		for (i = 0; i < 2; i++) begin
			@(posedge clock) fld <= 1'b1;
			settle(100);
			@(posedge clock) {shl, pau} <= (i == 0) ? 2'b01 : 2'b10;
			settle(100);
			@(posedge clock) {shl, pau} <= 2'b00;
			settle(100);
			rd(8'h0c, 32'h9, (i == 0) ? 32'h1 : 32'h9, "mode");
			wr(8'h0c, 32'h1);
			@(posedge clock) fld <= 1'b0;
			settle(100);
		end
		$display("mode test done");
		settle(8000);
		rd(8'h0c, 32'h80, 32'h0, "rx ended");
		@(posedge clock) fld <= 1'b1;
		settle(100);
		n = answer_edges;
		wr(8'h14, 32'h0);
		rd(8'h0c, 32'h40, 32'h40, "tx busy");
		frame(9'h1a6);
		settle(64);
		check("answer pulses", answer_edges - n, 32'd40);
		rd(8'h0c, 32'h40, 32'h0, "tx idle");
		rd(8'h10, 32'h1ff, 32'h1a6, "rx byte");
		rd(8'h0c, 32'h84, 32'h4, "rx flag");
		@(posedge clock) fld <= 1'b0;
		$display("answer and receive test done");
		wrap_up();
	end
endmodule
